// [rtl/apc_config_port.v]
`include "apc_defines.vh"

module apc_config_port (
    input wire core_clk,
    input wire rst,
    input wire select_low_in,
    input wire select_high_in,
    input wire write_strobe_n,
    input wire read_strobe_n,
    input wire [`APC_BYTE_W-1:0] config_byte_bus_in,
    output wire [`APC_BYTE_W-1:0] config_byte_bus_out,
    output wire [`APC_BYTE_W-1:0] config_byte_bus_oe,
    input wire init_n_in,
    output wire init_n_out,
    output wire init_n_oe,
    input wire [`APC_MODE_W-1:0] config_mode_pins,
    output wire [`APC_ADDR_W-1:0] prom_address_out,
    output wire prom_address_oe,
    input wire clear_done,
    input wire config_error,
    input wire config_done,
    output wire byte_valid,
    output wire [`APC_BYTE_W-1:0] byte_data,
    input wire byte_ready,
    output wire [`APC_MODE_W-1:0] config_mode,
    output wire loading,
    output wire user_mode
);
    // Sequencer states.
    localparam [4:0] ST_CLEAR = `APC_ST_CLEAR;
    localparam [4:0] ST_HOLD = `APC_ST_HOLD;
    localparam [4:0] ST_DELAY = `APC_ST_DELAY;
    localparam [4:0] ST_LOAD = `APC_ST_LOAD;
    localparam [4:0] ST_USER = `APC_ST_USER;

    reg [4:0] state_q;
    reg [4:0] state_d;
    reg [`APC_MODE_W-1:0] mode_q;
    reg error_q;
    reg [`APC_BYTE_W-1:0] buf_q;
    reg full_q;
    reg wr_act_q;
    reg [`APC_BYTE_W-1:0] bus_out_q;
    reg bus_oe_q;
    reg [`APC_ADDR_W-1:0] addr_q;
    reg addr_oe_q;
    reg [`APC_SETTLE_W-1:0] settle_q;

    wire [7:0] ctl_s;
    wire [`APC_BYTE_W-1:0] data_s;
    wire sel_low_s;
    wire sel_high_s;
    wire ws_n_s;
    wire rs_n_s;
    wire init_s;
    wire [`APC_MODE_W-1:0] mode_s;
    wire wait_done;
    wire is_master;
    wire is_mpar;
    wire is_chain;
    wire is_host;
    wire selected;
    wire wr_act;
    wire wr_edge;
    wire rd_act;
    wire take;
    wire mp_fetch;

    // Every pin input crosses two flops before any logic looks at it.
    // The host strobes and selects are asynchronous to the configuration clock, so
    // a single flop could hand a half-settled level to several decoders at once.
    // All control pins share one chain so their relative timing is preserved.
    // The price is two cycles of latency on every strobe edge.
    apc_sync #(
        .W(8)
    ) u_ctl_sync (
        .core_clk(core_clk),
        .rst(rst),
        .async_in({config_mode_pins, init_n_in, read_strobe_n, write_strobe_n,
                   select_high_in, select_low_in}),
        .sync_out(ctl_s)
    );

    // Data goes through the same depth so it lines up with the strobe.
    // A host that changes data with the falling strobe still lands a settled byte,
    // because capture waits for the synchronised strobe, two cycles later.
    apc_sync #(
        .W(`APC_BYTE_W)
    ) u_data_sync (
        .core_clk(core_clk),
        .rst(rst),
        .async_in(config_byte_bus_in),
        .sync_out(data_s)
    );

    assign sel_low_s = ctl_s[0];
    assign sel_high_s = ctl_s[1];
    assign ws_n_s = ctl_s[2];
    assign rs_n_s = ctl_s[3];
    assign init_s = ctl_s[4];
    assign mode_s = ctl_s[7:5];

    // Mode decode from the value latched when init rose.
    // Only the latched copy steers the port, so mode pins that move later are harmless.
    // The hold-off decision alone uses the live synchronised pins, on the very cycle
    // that the latch is loaded, so both see the same value.
    assign is_mpar = (mode_q == `APC_MODE_MPAR);
    assign is_chain = (mode_q == `APC_MODE_EXPR);
    assign is_host = (mode_q == `APC_MODE_APER) || is_chain;
    assign is_master = (mode_s == `APC_MODE_MSER) || (mode_s == `APC_MODE_MPAR);

    // In chained mode the upstream enable alone grants the port; otherwise both selects.
    // Select is qualified after synchronisation, so a select that moves together with
    // the strobe is judged on the same cycle as the strobe itself.
    assign selected = is_chain ? sel_high_s : (~sel_low_s & sel_high_s);

    // The port only listens while loading in a strobed mode, so user-mode toggling is ignored.
    // The write is acted on at its synchronised falling edge only; a strobe held low
    // for many cycles still yields one byte.
    // A read during that write is ignored, which keeps the data pins from fighting.
    assign wr_act = (state_q == ST_LOAD) && is_host && selected && ~ws_n_s;
    assign wr_edge = wr_act && ~wr_act_q;
    // Write beats read when both strobes are low; host is expected not to do this.
    assign rd_act = (state_q == ST_LOAD) && is_host && selected && ~rs_n_s && ~wr_act;

    // A byte already waiting is never overwritten; a host that ignores busy loses its byte.
    // In master parallel mode the fetch waits for an empty buffer and a settled address,
    // so a slow consumer simply stretches the memory cycle.
    assign take = full_q && byte_ready;
    assign mp_fetch = (state_q == ST_LOAD) && is_mpar && ~full_q && (settle_q == `APC_PROM_SETTLE);

    // Master-mode hold-off timer, started on the way into the delay state.
    // The timer is held at zero outside the delay state, so every entry waits the
    // full least hold-off; the longest allowed wait is never approached.
    // The done output is combinational so the state leaves on the last counted cycle.
    apc_wait_timer u_wait (
        .core_clk(core_clk),
        .rst(rst),
        .start(state_q != ST_DELAY),
        .run(state_q == ST_DELAY),
        .done(wait_done)
    );

    // Sequencer next state.
    // Clearing, hold-off, optional master delay, loading and user mode follow in a
    // fixed order; only reset, or an illegal code through the default branch,
    // returns the sequencer to clearing.
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_CLEAR: begin
                if (clear_done) begin
                    state_d = ST_HOLD;
                end
            end
            ST_HOLD: begin
                // An outside party holding init low keeps the device here.
                if (init_s) begin
                    state_d = is_master ? ST_DELAY : ST_LOAD;
                end
            end
            ST_DELAY: begin
                if (wait_done) begin
                    state_d = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (config_done) begin
                    state_d = ST_USER;
                end
            end
            ST_USER: begin
                state_d = ST_USER;
            end
            default: begin
                state_d = ST_CLEAR;
            end
        endcase
    end

    // State register and mode latch taken on the cycle init is seen high.
    // The latch is loaded only once per reset, so mode pins reused as user pins later
    // cannot change the decode.
    // Reset also returns the latch to master serial, the quietest decode.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_CLEAR;
            mode_q <= `APC_MODE_MSER;
        end else begin
            state_q <= state_d;
            if (state_q == ST_HOLD && init_s) begin
                mode_q <= mode_s;
            end
        end
    end

    // Error flag is sticky for the rest of the load and cleared only by reset.
    // Keeping it sticky means a one-cycle error pulse still holds init low until loading
    // ends or the host restarts the device.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            error_q <= 1'b0;
        end else if (state_q == ST_LOAD && config_error) begin
            error_q <= 1'b1;
        end
    end

    // Byte buffer shared by the strobed port and the memory fetch.
    // Capture only ever happens into an empty buffer and consumption only from a full
    // one, so set and clear of the pending flag never meet in one cycle. The previous
    // strobe level is tracked even while full, so a lost write is not replayed later.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            buf_q <= {`APC_BYTE_W{1'b0}};
            full_q <= 1'b0;
            wr_act_q <= 1'b0;
        end else begin
            wr_act_q <= wr_act;
            if (wr_edge && !full_q) begin
                buf_q <= data_s;
                full_q <= 1'b1;
            end else if (mp_fetch) begin
                buf_q <= data_s;
                full_q <= 1'b1;
            end else if (take) begin
                full_q <= 1'b0;
            end
        end
    end

    // Status readback drives ready on the top bit and ones below it.
    // The data pins are driven one cycle after the synchronised read strobe and
    // released the same way, so the host sees about three cycles of turnaround.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            bus_out_q <= {`APC_BYTE_W{1'b0}};
            bus_oe_q <= 1'b0;
        end else begin
            bus_out_q <= {~full_q, `APC_STATUS_LOW};
            bus_oe_q <= rd_act;
        end
    end

    // Memory address walks one step per consumed byte, after a settling delay.
    // The address drive is computed from the next state so it appears together with
    // the loading state and drops together with it. The settle count covers the two
    // synchroniser stages plus memory access time.
    // The address stays on its last value once loading ends, with its drive removed.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            addr_q <= {`APC_ADDR_W{1'b0}};
            addr_oe_q <= 1'b0;
            settle_q <= {`APC_SETTLE_W{1'b0}};
        end else begin
            addr_oe_q <= (state_d == ST_LOAD) && is_mpar;
            if (state_q != ST_LOAD || !is_mpar) begin
                settle_q <= {`APC_SETTLE_W{1'b0}};
            end else if (take) begin
                addr_q <= addr_q + 1'b1;
                settle_q <= {`APC_SETTLE_W{1'b0}};
            end else if (!full_q && settle_q != `APC_PROM_SETTLE) begin
                settle_q <= settle_q + 1'b1;
            end
        end
    end

    // Init is open drain: only ever pulled low, while clearing and after a load error.
    // The pull-up outside the device raises the line; the device never drives it high,
    // so another party holding it low always wins.
    assign init_n_out = 1'b0;
    assign init_n_oe = (state_q == ST_CLEAR) || (state_q == ST_LOAD && error_q);

    // Outputs are flops or plain decodes of the state register, so no pin sees a
    // combinational path from another pin.
    assign config_byte_bus_out = bus_out_q;
    assign config_byte_bus_oe = {`APC_BYTE_W{bus_oe_q}};
    assign prom_address_out = addr_q;
    assign prom_address_oe = addr_oe_q;
    assign byte_valid = full_q;
    assign byte_data = buf_q;
    assign config_mode = mode_q;
    assign loading = (state_q == ST_LOAD);
    assign user_mode = (state_q == ST_USER);
endmodule // apc_config_port

// [common/apc_defines.vh]
`ifndef APC_DEFINES_VH
`define APC_DEFINES_VH

// Widths of the pin groups.
`define APC_BYTE_W 8
`define APC_ADDR_W 18
`define APC_MODE_W 3

// Configuration mode codes as read from the three mode pins (M2 M1 M0).
`define APC_MODE_MSER 3'h0
`define APC_MODE_EXPR 3'h2
`define APC_MODE_MPAR 3'h6
`define APC_MODE_APER 3'h5

// Readback of a status access: lower seven data bits are driven high.
`define APC_STATUS_LOW 7'h7f

// Master-mode hold-off after the init line rises, least value 30 us.
`define APC_CLK_PERIOD_NS 8
`define APC_WAIT_MIN_NS 30000
`define APC_WAIT_CYCLES ((`APC_WAIT_MIN_NS + `APC_CLK_PERIOD_NS - 1) / `APC_CLK_PERIOD_NS)
`define APC_WAIT_W 12

// Cycles the memory data is given to settle after each address step.
`define APC_PROM_SETTLE 3'h4
`define APC_SETTLE_W 3

// One-hot sequencer states.
`define APC_ST_CLEAR 5'h01
`define APC_ST_HOLD 5'h02
`define APC_ST_DELAY 5'h04
`define APC_ST_LOAD 5'h08
`define APC_ST_USER 5'h10

`endif

// [rtl/apc_sync.v]
// Two-stage synchroniser, one chain per bit.
module apc_sync #(
    parameter W = 1
) (
    input wire core_clk,
    input wire rst,
    input wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg meta_q;
            reg stable_q;
            // The first stage feeds only the second, so metastability has a full cycle to settle.
            always @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    meta_q <= 1'b1;
                    stable_q <= 1'b1;
                end else begin
                    meta_q <= async_in[i];
                    stable_q <= meta_q;
                end
            end
            assign sync_out[i] = stable_q;
        end
    endgenerate
endmodule // apc_sync

// [rtl/apc_wait_timer.v]
`include "apc_defines.vh"

// Counts the master-mode hold-off and flags its end.
module apc_wait_timer (
    input wire core_clk,
    input wire rst,
    input wire start,
    input wire run,
    output wire done
);
    localparam [31:0] LAST_FULL = `APC_WAIT_CYCLES - 1;
    localparam [`APC_WAIT_W-1:0] LAST = LAST_FULL[`APC_WAIT_W-1:0];
    reg [`APC_WAIT_W-1:0] cnt_q;

    // The count restarts on every start so a re-entered wait is always full length.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= {`APC_WAIT_W{1'b0}};
        end else if (start) begin
            cnt_q <= {`APC_WAIT_W{1'b0}};
        end else if (run && cnt_q != LAST) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    assign done = run && (cnt_q == LAST);
endmodule // apc_wait_timer

// [sim/apc_prom_model.sv]
`include "apc_defines.vh"
// External configuration memory; each location holds its low address bits xor 8'h5a.
module apc_prom_model (
    input wire core_clk,
    input wire [`APC_ADDR_W-1:0] addr,
    input wire addr_oe,
    output wire [`APC_BYTE_W-1:0] data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [`APC_BYTE_W-1:0] flip_q = 8'h00;
    // A stale value must not look like data, so an undriven address shows a toggling byte.
    always @(posedge core_clk) begin
        flip_q <= ~flip_q;
    end
    assign data = addr_oe ? (addr[7:0] ^ 8'h5a) : flip_q;
endmodule // apc_prom_model

// [sim/apc_port_properties.sv]
`include "apc_defines.vh"
// Watches the loader pins; helper counter measures the master hold-off.
module apc_port_checker (
    input wire core_clk,
    input wire rst,
    input wire select_low_in,
    input wire select_high_in,
    input wire write_strobe_n,
    input wire init_n_in,
    input wire init_n_oe,
    input wire [7:0] config_byte_bus_out,
    input wire [7:0] config_byte_bus_oe,
    input wire [17:0] prom_address_out,
    input wire prom_address_oe,
    input wire clear_done,
    input wire config_error,
    input wire byte_valid,
    input wire [7:0] byte_data,
    input wire byte_ready,
    input wire [2:0] config_mode,
    input wire loading,
    input wire user_mode
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic [15:0] wait_q;
    // Cycles since the init pin went high; the pin leads the design by two stages.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) wait_q <= 16'h0;
        else if (!init_n_in) wait_q <= 16'h0;
        else if (wait_q != 16'hffff) wait_q <= wait_q + 16'h1;
    end
    sequence s_unsel; (select_low_in || !select_high_in) [*5]; endsequence
    sequence s_wr_held; !write_strobe_n [*6]; endsequence
    sequence s_take; byte_valid && byte_ready; endsequence
    property p_clear; init_n_oe && !clear_done && !loading |=> init_n_oe; endproperty
    property p_hold; !init_n_in [*3] ##0 !loading |=> !loading; endproperty
    property p_delay;
        $rose(loading) && (config_mode == `APC_MODE_MPAR || config_mode == `APC_MODE_MSER)
            |-> wait_q >= 16'd3750 && wait_q <= 16'd37500;
    endproperty
    property p_err; loading && config_error |-> ##[1:3] init_n_oe; endproperty
    property p_user;
        user_mode && $past(user_mode) |-> !init_n_oe && !prom_address_oe && !loading
            && config_byte_bus_oe == 8'h0;
    endproperty
    property p_busy; byte_valid && !byte_ready |=> byte_valid && $stable(byte_data); endproperty
    property p_take; s_take |=> !byte_valid; endproperty
    property p_status;
        config_byte_bus_oe != 8'h0 |-> config_byte_bus_oe == 8'hff
            && config_byte_bus_out[6:0] == `APC_STATUS_LOW;
    endproperty
    property p_unsel; s_unsel ##0 config_mode == `APC_MODE_APER |-> !$rose(byte_valid); endproperty
    property p_wr_wins; s_wr_held |-> config_byte_bus_oe == 8'h0; endproperty
    property p_addr;
        s_take ##0 prom_address_oe |=> prom_address_out == $past(prom_address_out) + 18'h1;
    endproperty
    a_clear: assert property (p_clear) else $error("init released early");
    a_hold: assert property (p_hold) else $error("load while init low");
    a_delay: assert property (p_delay) else $error("hold-off length");
    a_err: assert property (p_err) else $error("error not on init");
    a_user: assert property (p_user) else $error("port pins still used");
    a_busy: assert property (p_busy) else $error("pending byte lost");
    a_take: assert property (p_take) else $error("byte not consumed");
    a_status: assert property (p_status) else $error("status byte wrong");
    a_unsel: assert property (p_unsel) else $error("capture unselected");
    a_wr_wins: assert property (p_wr_wins) else $error("read during write");
    a_addr: assert property (p_addr) else $error("address step");
endmodule // apc_port_checker
bind apc_config_port apc_port_checker i_apc_port_checker (.*);

// [sim/test_async_peripheral_config_port.sv]
`include "apc_defines.vh"
module test_async_peripheral_config_port;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0, rst = 1'b1, select_low_in = 1'b1, select_high_in = 1'b0;
    logic write_strobe_n = 1'b1, read_strobe_n = 1'b1, hold_q = 1'b0, clear_done = 1'b0;
    logic config_error = 1'b0, config_done = 1'b0, byte_ready = 1'b0;
    logic [7:0] host_q = 8'h00;
    logic [2:0] config_mode_pins = 3'h0;
    wire [7:0] config_byte_bus_out, config_byte_bus_oe, config_byte_bus_in, byte_data, prom_d;
    wire [17:0] prom_address_out;
    wire [2:0] config_mode;
    wire init_n_out, init_n_oe, prom_address_oe, byte_valid, loading, user_mode;
    int failures = 0, num_checks = 0, n;
    // Open-drain init with its pull-up; the bench may also hold it low.
    wire init_n_in = ~((init_n_oe & ~init_n_out) | hold_q);
    // Each data pin follows whoever drives it: the port, the memory or the host.
    assign config_byte_bus_in = (config_byte_bus_oe & config_byte_bus_out)
        | (~config_byte_bus_oe & (prom_address_oe ? prom_d : host_q));
    apc_config_port i_apc_config_port (.*);
    apc_prom_model i_apc_prom_model (.core_clk(core_clk), .addr(prom_address_out),
        .addr_oe(prom_address_oe), .data(prom_d));
    initial forever #4 core_clk = ~core_clk;
    task automatic step(input int c);
        repeat (c) @(posedge core_clk);
        #1;
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_val(input logic [17:0] got, input logic [17:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Resets, clears memory, holds init low a while, then lets the mode be taken.
    task automatic start(input logic [2:0] m, input int lo);
        @(posedge core_clk);
        {rst, hold_q, clear_done, config_done} <= 4'hc;
        config_mode_pins <= m;
        step(2);
        @(posedge core_clk);
        rst <= 1'b0;
        step(4);
        chk_bit(init_n_in, 1'b0);
        @(posedge core_clk);
        clear_done <= 1'b1;
        step(20);
        chk_bit(loading, 1'b0);
        @(posedge core_clk);
        hold_q <= 1'b0;
        step(lo);
        chk_bit(loading, 1'b0);
        for (n = 0; n < 200 && !loading; n++) step(1);
        chk_bit(loading, 1'b1);
        chk_val(config_mode, m);
    endtask
    // One host access; both strobes low exercises the collision case.
    task automatic wr(input logic [7:0] d, input logic sl, sh, both);
        @(posedge core_clk);
        {host_q, select_low_in, select_high_in, write_strobe_n} <= {d, sl, sh, 1'b0};
        read_strobe_n <= ~both;
        step(5);
        chk_val(config_byte_bus_oe, 8'h00);
        @(posedge core_clk);
        {select_low_in, select_high_in, write_strobe_n, read_strobe_n} <= 4'hb;
        step(4);
    endtask
    task automatic rd(input logic [7:0] exp);
        @(posedge core_clk);
        {select_low_in, select_high_in, read_strobe_n} <= 3'h2;
        step(5);
        chk_val(config_byte_bus_in, exp);
        @(posedge core_clk);
        {select_low_in, select_high_in, read_strobe_n} <= 3'h5;
        step(5);
    endtask
    task automatic take;
        @(posedge core_clk);
        byte_ready <= 1'b1;
        @(posedge core_clk);
        byte_ready <= 1'b0;
        step(0);
        chk_bit(byte_valid, 1'b0);
    endtask
    task automatic finish_cfg;
        @(posedge core_clk);
        {config_error, config_done} <= 2'h1;
        step(4);
        chk_bit(user_mode, 1'b1);
        chk_bit(init_n_in, 1'b1);
        chk_bit(prom_address_oe, 1'b0);
        wr(8'h77, 1'b0, 1'b1, 1'b0);
        chk_bit(byte_valid, 1'b0);
    endtask
    task automatic t_async;
        start(`APC_MODE_APER, 0);
        rd(8'hff);
        wr(8'h3c, 1'b0, 1'b1, 1'b0);
        chk_val(byte_data, 8'h3c);
        rd(8'h7f);
        wr(8'h99, 1'b0, 1'b1, 1'b0);
        chk_val(byte_data, 8'h3c);
        take;
        wr(8'h11, 1'b1, 1'b1, 1'b0);
        wr(8'h22, 1'b0, 1'b0, 1'b0);
        chk_bit(byte_valid, 1'b0);
        wr(8'h5e, 1'b0, 1'b1, 1'b1);
        chk_val(byte_data, 8'h5e);
        take;
        @(posedge core_clk);
        config_error <= 1'b1;
        step(4);
        chk_bit(init_n_in, 1'b0);
        finish_cfg;
    endtask
    task automatic t_chain;
        start(`APC_MODE_EXPR, 0);
        wr(8'ha5, 1'b1, 1'b1, 1'b0);
        chk_val(byte_data, 8'ha5);
        take;
        wr(8'h0f, 1'b0, 1'b0, 1'b0);
        chk_bit(byte_valid, 1'b0);
        finish_cfg;
    endtask
    task automatic t_mser;
        start(`APC_MODE_MSER, 3740);
        wr(8'h42, 1'b0, 1'b1, 1'b0);
        chk_bit(byte_valid, 1'b0);
        chk_bit(prom_address_oe, 1'b0);
        finish_cfg;
    endtask
    task automatic t_mpar;
        start(`APC_MODE_MPAR, 3740);
        for (n = 0; n < 3; n++) begin
            step(8);
            chk_val(prom_address_out, n);
            chk_val(byte_data, n ^ 8'h5a);
            take;
        end
        finish_cfg;
    endtask
    task automatic report_and_stop;
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        t_async;
        t_chain;
        t_mser;
        t_mpar;
        report_and_stop;
    end
    // The whole run is near 63 us, so 200 us means a hang.
    initial begin
        #200000;
        failures++;
        report_and_stop;
    end
endmodule // test_async_peripheral_config_port
